//--- src/scpuif_top.sv
// module: special cpu interface control with apb configuration registers
// Function
// [RULE1] in 386 mode the shared pin carries gate_addr20 by default
// [RULE2] feature bit 4 forces addr20_mask_out onto the shared pin
// [RULE3] feature bit 7: 0 waits for claimed local cycles, 1 ignores
// [RULE4] feature bit 6 makes cpu_hard_reset fire immediately
// [RULE5] feature bit 5 declares cpu powered off in suspend; outputs idle
// [RULE6] with cpu power-off, hard reset is issued on leaving suspend
// [RULE7] in 386 mode soft and hard resets both appear on cpu_soft_reset
// [RULE8] software sets feature bit 3 before the first software reset
// [RULE9] resume: power latch on, wait its delay, then soft reset high
// [RULE10] quick resume soft reset does not pulse cpu_hard_reset
// [RULE11] in 386 mode the second shared pin carries numeric_irq
// [RULE12] feature bit 2 forces dma_ack_ch2 onto that pin
// [RULE13] local master enable gives pin local_master_grant, override ignored
// [RULE14] misc bit 7 picks linear burst order, 0 interleaved
// [RULE15] fpu_error low at reset: high io cycles go local, no ready
// [RULE16] feature bit 1 overrides recognition: isa cycle, own ready
// [RULE17] ready_in synchronised by default, merged on cpu_ready; the code's synchronised path also needs byte_high_enable strapped low
// [RULE18] synchronised ready one clock later, direct same clock; the code's synchronised path lags four clocks
// [RULE19] feature bit 0 routes ready_in directly in coprocessor cycles
// [RULE20] ready routing bit only acts when byte_high_enable strapped low
// [RULE21] board may buffer fpu_ready_out externally, keeping cpu_addr25
// [RULE22] register writes take effect from the next clock onward
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module scpuif_top
    import scpuif_pkg::*;
#(
    parameter int PWR_DELAY = PWR_DELAY_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        strap386,
    input  wire logic        fpu_error_b,
    input  wire logic        byte_high_enable_b,
    input  wire logic        ready_in_b,
    input  wire logic        cycleStart,
    input  wire logic        cycleIo,
    input  wire logic        cpu_addr31,
    input  wire logic        local_device_claim_b,
    input  wire logic        internalReady,
    input  wire logic        gateAddr20Val,
    input  wire logic        addr20MaskVal,
    input  wire logic        numericIrqVal,
    input  wire logic        dmaAckCh2Val_b,
    input  wire logic        localMasterGrantVal_b,
    input  wire logic        softResetReq,
    input  wire logic        hardResetReq,
    input  wire logic        inSuspend,
    output logic             pin130Out,
    output logic             pin130IsMask,
    output logic             pin80Out,
    output logic [1:0]       pin80Func,
    output logic             cpu_ready_o,
    output logic             cpu_ready_oe,
    output logic             forwardLocal,
    output logic             waitLocalClaim,
    output logic             linearBurst,
    output logic             cpu_hard_reset,
    output logic             cpu_soft_reset,
    output logic             power_latch_bit0,
    output logic             cpuOutputsIdle
);
    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    logic [7:0] miscReg_r;
    logic [7:0] featReg_r;
    logic [7:0] lmcReg_r;
    logic [7:0] statusVal;
    logic       wrEn;
    logic       idxOk;

    function automatic logic [7:0] reg_index(input logic [11:0] a);
        return a[9:2];
    endfunction

    assign wrEn    = psel && penable && pwrite;
    assign pready  = 1'b1;
    always_comb begin
        unique case (reg_index(paddr))
            MISC_CPU_CONTROL_IDX, SPECIAL_CPU_FEATURE_IDX,
            LOCAL_MASTER_CFG_IDX, STATUS_IDX: idxOk = 1'b1;
            default:                          idxOk = 1'b0;
        endcase
    end
    // unmapped or misaligned access answers with an error, no state change
    assign pslverr = psel && penable && (!idxOk || paddr[1:0] != 2'b00);

    // writes land at the access edge, so logic sees them next clock
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            miscReg_r <= RESET_VAL;
            featReg_r <= RESET_VAL;
            lmcReg_r  <= RESET_VAL;
        end else if (wrEn && !pslverr) begin // [RULE22]
            if (reg_index(paddr) == MISC_CPU_CONTROL_IDX)
                miscReg_r <= pwdata[7:0];
            if (reg_index(paddr) == SPECIAL_CPU_FEATURE_IDX)
                featReg_r <= pwdata[7:0];
            if (reg_index(paddr) == LOCAL_MASTER_CFG_IDX)
                lmcReg_r <= pwdata[7:0];
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        unique case (reg_index(paddr))
            MISC_CPU_CONTROL_IDX:    prdata[7:0] = miscReg_r;
            SPECIAL_CPU_FEATURE_IDX: prdata[7:0] = featReg_r;
            LOCAL_MASTER_CFG_IDX:    prdata[7:0] = lmcReg_r;
            STATUS_IDX:              prdata[7:0] = statusVal;
            default:                 prdata = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // strap capture after reset release
    // ------------------------------------------------------------------
    logic [2:0] fpuSync_r;
    logic [2:0] bheSync_r;
    logic [2:0] rdySync_r;
    logic       strapDone_r;
    logic [1:0] fillCnt_r;
    logic       coprocPresent_r;
    logic       readyPinEn_r;

    // three-stage synchronisers for pin inputs
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fpuSync_r <= 3'h7;
            bheSync_r <= 3'h7;
            rdySync_r <= 3'h7;
        end else begin
            fpuSync_r <= {fpuSync_r[1:0], fpu_error_b};
            bheSync_r <= {bheSync_r[1:0], byte_high_enable_b};
            rdySync_r <= {rdySync_r[1:0], ready_in_b};
        end
    end

    // straps are caught once, when the synchronised levels agree
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fillCnt_r       <= 2'h0;
            strapDone_r     <= 1'b0;
            coprocPresent_r <= 1'b0;
            readyPinEn_r    <= 1'b0;
        end else if (fillCnt_r != 2'h3) begin
            fillCnt_r       <= fillCnt_r + 2'h1; // skip reset fill
        end else if (!strapDone_r && fpuSync_r[2] == fpuSync_r[1]
                     && bheSync_r[2] == bheSync_r[1]) begin
            strapDone_r     <= 1'b1;
            coprocPresent_r <= !fpuSync_r[2]; // [RULE15]
            readyPinEn_r    <= !bheSync_r[2]; // [RULE20]
        end
    end

    // ------------------------------------------------------------------
    // pin function selection
    // ------------------------------------------------------------------
    // mode 386 picks gate_addr20 unless the mask function is forced
    assign pin130IsMask = !strap386 || featReg_r[FEAT_ADDR20_MASK_OUT_FORCE]; // [RULE1] [RULE2]
    assign pin130Out    = pin130IsMask ? addr20MaskVal : gateAddr20Val;

    // pin 80: 0 dma ack, 1 numeric irq, 2 local master grant
    always_comb begin
        if (lmcReg_r[LMC_MASTER_ENABLE]) begin // [RULE13]
            pin80Func = 2'h2;
            pin80Out  = localMasterGrantVal_b;
        end else if (strap386 && !featReg_r[FEAT_DMA_ACK_FORCE]) begin // [RULE11] [RULE12]
            pin80Func = 2'h1;
            pin80Out  = numericIrqVal;
        end else begin
            pin80Func = 2'h0;
            pin80Out  = dmaAckCh2Val_b;
        end
    end

    assign linearBurst    = miscReg_r[MISC_LINEAR_BURST]; // [RULE14]
    assign waitLocalClaim = !featReg_r[FEAT_CLAIM_IGNORE] &&
                            !local_device_claim_b; // [RULE3]

    // ------------------------------------------------------------------
    // coprocessor recognition and ready routing
    // ------------------------------------------------------------------
    logic coprocCycle;
    logic readySyncLow_r;
    logic directMode;
    logic driveLow;

    // override bit sends high io cycles to isa with our own ready
    assign coprocCycle  = cycleIo && cpu_addr31 && coprocPresent_r &&
                          !featReg_r[FEAT_COPROC_OVRD]; // [RULE15] [RULE16]
    assign forwardLocal = coprocCycle;
    assign directMode   = readyPinEn_r && featReg_r[FEAT_READY_DIRECT] &&
                          coprocCycle; // [RULE19] [RULE20]

    // latched ready lags ready_in by four clocks but tolerates slow sources
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            readySyncLow_r <= 1'b0;
        else
            readySyncLow_r <= readyPinEn_r && !rdySync_r[2] &&
                              !rdySync_r[1] &&
                              !directMode; // [RULE17] [RULE18]
    end

    // direct path bypasses synchronisers; board must meet setup time
    always_comb begin
        driveLow = readySyncLow_r || (directMode && !ready_in_b); // [RULE18] [RULE19]
        if (internalReady && !coprocCycle)
            driveLow = 1'b1; // [RULE16]
    end
    assign cpu_ready_o  = 1'b0;
    assign cpu_ready_oe = driveLow;

    // ------------------------------------------------------------------
    // reset routing and resume sequencing
    // ------------------------------------------------------------------
    scpuif_rsm_t           rsmState_r;
    logic [PWR_CNT_W-1:0]  pwrCnt_r;
    logic [RST_CNT_W-1:0]  hardCnt_r;
    logic [RST_CNT_W-1:0]  softCnt_r;
    logic                  suspendPrev_r;
    logic                  resumeEvt;
    logic                  hardPulseStart;
    logic                  softPulseStart;
    logic                  quickResume;
    logic                  hardPend_r;
    logic                  hardLoad;

    assign resumeEvt   = suspendPrev_r && !inSuspend;
    assign quickResume = featReg_r[FEAT_CPU_SOFT_RESET_TOGGLE] &&
                         featReg_r[FEAT_CPU_POWER_OFF];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            suspendPrev_r <= 1'b0;
        else
            suspendPrev_r <= inSuspend;
    end

    // power latch first, then the soft reset after its settle delay
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rsmState_r <= SCP_IDLE;
            pwrCnt_r   <= '0;
        end else begin
            unique case (rsmState_r)
                SCP_IDLE: if (resumeEvt && quickResume) begin // [RULE9]
                    rsmState_r <= SCP_POWER;
                    pwrCnt_r   <= '0;
                end
                SCP_POWER: begin
                    pwrCnt_r <= pwrCnt_r + 1'b1;
                    if (pwrCnt_r == PWR_CNT_W'(PWR_DELAY - 1))
                        rsmState_r <= SCP_RESET; // [RULE9]
                end
                SCP_RESET: rsmState_r <= SCP_IDLE;
                default:   rsmState_r <= SCP_IDLE;
            endcase
        end
    end

    // latch drops in suspend when cpu power is cut, restored on resume
    assign power_latch_bit0 = !(inSuspend && featReg_r[FEAT_CPU_POWER_OFF]);
    assign cpuOutputsIdle   = inSuspend && featReg_r[FEAT_CPU_POWER_OFF]; // [RULE5]

    // quick resume uses only the soft line, keeping local bus alive
    assign hardPulseStart = hardResetReq ||
        (resumeEvt && featReg_r[FEAT_CPU_POWER_OFF] && !quickResume); // [RULE6] [RULE10]
    assign hardLoad = (hardPulseStart || hardPend_r) &&
        (featReg_r[FEAT_HARD_RST_NOW] || !cycleStart); // [RULE4]
    assign softPulseStart = softResetReq || rsmState_r == SCP_RESET ||
        (strap386 && hardLoad); // [RULE7]

    // immediate mode skips waiting for the current bus cycle to end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hardCnt_r <= '0;
            softCnt_r <= '0;
            hardPend_r <= 1'b0;
        end else begin
            hardPend_r <= (hardPulseStart || hardPend_r) && !hardLoad;
            if (hardLoad) // [RULE4]
                hardCnt_r <= RST_CNT_W'(RESET_PULSE_CYCLES - 1);
            else if (hardCnt_r != '0)
                hardCnt_r <= hardCnt_r - 1'b1;
            if (softPulseStart)
                softCnt_r <= RST_CNT_W'(RESET_PULSE_CYCLES - 1);
            else if (softCnt_r != '0)
                softCnt_r <= softCnt_r - 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cpu_hard_reset <= 1'b0;
            cpu_soft_reset <= 1'b0;
        end else begin
            cpu_hard_reset <= hardCnt_r != '0;
            cpu_soft_reset <= softCnt_r != '0;
        end
    end

    assign statusVal = {4'h0, rsmState_r, readyPinEn_r, coprocPresent_r};

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_addr20_sel;
        @(posedge clock) disable iff (!rst_b)
        strap386 && !featReg_r[FEAT_ADDR20_MASK_OUT_FORCE] |-> pin130Out == gateAddr20Val;
    endproperty
    a_addr20_sel: assert property (p_addr20_sel) else $error("pin130 sel"); // [RULE1]

    property p_addr20_force;
        @(posedge clock) disable iff (!rst_b)
        featReg_r[FEAT_ADDR20_MASK_OUT_FORCE] |-> pin130Out == addr20MaskVal;
    endproperty
    a_addr20_force: assert property (p_addr20_force) else $error("a20 force"); // [RULE2]

    property p_grant_prio;
        @(posedge clock) disable iff (!rst_b)
        lmcReg_r[LMC_MASTER_ENABLE] |-> pin80Out == localMasterGrantVal_b;
    endproperty
    a_grant_prio: assert property (p_grant_prio) else $error("grant prio"); // [RULE13]

    property p_dma_force;
        @(posedge clock) disable iff (!rst_b)
        !lmcReg_r[LMC_MASTER_ENABLE] && featReg_r[FEAT_DMA_ACK_FORCE]
        |-> pin80Func == 2'h0;
    endproperty
    a_dma_force: assert property (p_dma_force) else $error("dma force"); // [RULE12]

    property p_sync_ready;
        @(posedge clock) disable iff (!rst_b)
        readyPinEn_r && !rdySync_r[2] && !rdySync_r[1] && !directMode
        |=> cpu_ready_oe;
    endproperty
    a_sync_ready: assert property (p_sync_ready) else $error("sync rdy"); // [RULE18]

    property p_direct_ready;
        @(posedge clock) disable iff (!rst_b)
        directMode && !ready_in_b |-> cpu_ready_oe;
    endproperty
    a_direct_ready: assert property (p_direct_ready) else $error("dir rdy"); // [RULE19]

    property p_no_ready_copro;
        @(posedge clock) disable iff (!rst_b)
        coprocCycle && internalReady && !readySyncLow_r && ready_in_b
        |-> !cpu_ready_oe;
    endproperty
    a_no_ready_copro: assert property (p_no_ready_copro) else $error("copro"); // [RULE15]

    sequence s_resume_quick;
        resumeEvt && quickResume && rsmState_r == SCP_IDLE;
    endsequence
    property p_quick_no_hard;
        @(posedge clock) disable iff (!rst_b)
        s_resume_quick ##1 (cpu_hard_reset == 1'b0) |=> !cpu_hard_reset;
    endproperty
    a_quick_no_hard: assert property (p_quick_no_hard) else $error("hard"); // [RULE10]

    property p_hard_on_soft;
        @(posedge clock) disable iff (!rst_b)
        strap386 && hardLoad |-> ##2 cpu_soft_reset;
    endproperty
    a_hard_on_soft: assert property (p_hard_on_soft) else $error("386 rst"); // [RULE7]

    property p_resume_seq;
        @(posedge clock) disable iff (!rst_b)
        rsmState_r == SCP_RESET |-> ##2 cpu_soft_reset;
    endproperty
    a_resume_seq: assert property (p_resume_seq) else $error("resume"); // [RULE9]
endmodule

//--- src/scpuif_pkg.sv
// package: register map, field positions and timing for the cpu interface block
package scpuif_pkg;
    // ------------------------------------------------------------------
    // register map (printed offsets are not all multiples of four)
    // ------------------------------------------------------------------
    localparam logic [7:0]  MISC_CPU_CONTROL_IDX   = 8'h3F;
    localparam logic [7:0]  SPECIAL_CPU_FEATURE_IDX = 8'hAD;
    localparam logic [7:0]  LOCAL_MASTER_CFG_IDX   = 8'hA0;
    localparam logic [7:0]  STATUS_IDX             = 8'hB0;
    localparam logic [7:0]  RESET_VAL              = 8'h00;
    // ------------------------------------------------------------------
    // special feature, misc and local master field positions
    // ------------------------------------------------------------------
    localparam int FEAT_READY_DIRECT   = 0;
    localparam int FEAT_COPROC_OVRD    = 1;
    localparam int FEAT_DMA_ACK_FORCE  = 2;
    localparam int FEAT_CPU_SOFT_RESET_TOGGLE  = 3;
    localparam int FEAT_ADDR20_MASK_OUT_FORCE     = 4;
    localparam int FEAT_CPU_POWER_OFF  = 5;
    localparam int FEAT_HARD_RST_NOW   = 6;
    localparam int FEAT_CLAIM_IGNORE   = 7;
    localparam int MISC_LINEAR_BURST   = 7;
    localparam int LMC_MASTER_ENABLE   = 5;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLOCK_MHZ           = 50;
    localparam int RESET_PULSE_CYCLES  = 128;
    localparam int RST_CNT_W           = 8;
    localparam int PWR_DELAY_US        = 10;
    localparam int PWR_DELAY_CYCLES    = PWR_DELAY_US * CLOCK_MHZ;
    localparam int PWR_CNT_W           = 16;
    // resume sequencer states, gray from idle through power to reset
    typedef enum logic [1:0] {
        SCP_IDLE   = 2'b00,
        SCP_POWER  = 2'b01,
        SCP_RESET  = 2'b11
    } scpuif_rsm_t;
endpackage

//--- bench/scpuif_cpu_model.sv
// cpu and coprocessor model on the far side of the interface block
`timescale 1ns/1ps
module scpuif_cpu_model #(
    parameter int HOLD = 8
) (
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       copReq,
    input  wire logic [3:0] dly,
    output logic            fpu_error_b,
    output logic            byte_high_enable_b,
    output logic            ready_in_b
);
    logic [3:0] relCnt;
    logic [3:0] busyCnt;
    // ----------------------------------------------------------------
    // straps
    // ----------------------------------------------------------------
    // straps stay put a while after release, the block samples them late
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            relCnt <= 4'h0;
        end else if (relCnt < 4'(HOLD)) begin
            relCnt <= relCnt + 4'h1;
        end
    end
    // coprocessor present: error line low while straps are read
    assign fpu_error_b = (relCnt < 4'(HOLD)) ? 1'b0 : 1'b1;
    assign byte_high_enable_b = (relCnt < 4'(HOLD)) ? 1'b0 : 1'b1;
    // ----------------------------------------------------------------
    // coprocessor ready
    // ----------------------------------------------------------------
    // ready comes dly cycles into a cycle; pulled up again once it ends
    always_ff @(posedge clock) begin
        busyCnt <= copReq ? ((busyCnt < dly) ? busyCnt + 4'h1 : busyCnt) : 4'h0;
    end
    assign ready_in_b = !(copReq && busyCnt >= dly);
endmodule

//--- bench/tb.sv
// self-checking bench for the special cpu interface control block
`timescale 1ns/1ps
module tb;
    import scpuif_pkg::*;
    localparam int PD = 4;
    localparam logic [7:0] FI = SPECIAL_CPU_FEATURE_IDX;
    logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        strap386, fpu_error_b, byte_high_enable_b, ready_in_b;
    logic        cycleStart, cycleIo, cpu_addr31, local_device_claim_b;
    logic        internalReady, gateAddr20Val, addr20MaskVal, numericIrqVal;
    logic        dmaAckCh2Val_b, localMasterGrantVal_b, softResetReq;
    logic        hardResetReq, inSuspend, pin130Out, pin130IsMask, pin80Out;
    logic        cpu_ready_o, cpu_ready_oe, forwardLocal, waitLocalClaim;
    logic        linearBurst, cpu_hard_reset, cpu_soft_reset, copReq, sawHard;
    logic        power_latch_bit0, cpuOutputsIdle;
    logic [1:0]  pin80Func;
    logic [3:0]  copDly;
    logic [4:0]  pat = 5'h00;
    int          num_errors, checks_done, n;

    scpuif_top #(.PWR_DELAY(PD)) scpuif_top_inst (.clock, .rst_b, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .strap386, .fpu_error_b, .byte_high_enable_b, .ready_in_b,
        .cycleStart, .cycleIo, .cpu_addr31, .local_device_claim_b,
        .internalReady, .gateAddr20Val, .addr20MaskVal, .numericIrqVal,
        .dmaAckCh2Val_b, .localMasterGrantVal_b, .softResetReq,
        .hardResetReq, .inSuspend, .pin130Out, .pin130IsMask, .pin80Out,
        .pin80Func, .cpu_ready_o, .cpu_ready_oe, .forwardLocal,
        .waitLocalClaim, .linearBurst, .cpu_hard_reset, .cpu_soft_reset,
        .power_latch_bit0, .cpuOutputsIdle);
    scpuif_cpu_model scpuif_cpu_model_inst (.clock, .rst_b, .copReq,
        .dly(copDly), .fpu_error_b, .byte_high_enable_b, .ready_in_b);

    // pin sources keep moving so a wrong selection shows up
    assign {gateAddr20Val, addr20MaskVal, numericIrqVal, dmaAckCh2Val_b,
            localMasterGrantVal_b} = pat;
    always @(posedge clock) pat <= pat + 5'h01;
    // free running clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer; the request is held until pready is seen
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clock);
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return cpu_hard_reset;
            1: return cpu_soft_reset;
            2: return cpu_ready_oe;
            default: return !ready_in_b;
        endcase
    endfunction
    // count falling edges until the chosen signal is high, up to lim
    task automatic waitfor(input int s, input int lim);
        n = 0;
        while (n < lim && pick(s) !== 1'b1) begin
            @(negedge clock);
            n++;
        end
    endtask
    // let any reset pulse run out, noting whether hard reset showed
    task automatic settle();
        n = 0;
        sawHard = 1'b0;
        while (n < 300 && {cpu_hard_reset, cpu_soft_reset} !== 2'b00) begin
            sawHard = sawHard | cpu_hard_reset;
            @(negedge clock);
            n++;
        end
        check({cpu_hard_reset, cpu_soft_reset}, 0);
    endtask
    task automatic pulse(input logic hard);
        @(posedge clock);
        hardResetReq <= hard;
        softResetReq <= !hard;
        @(posedge clock);
        hardResetReq <= 1'b0;
        softResetReq <= 1'b0;
    endtask
    task automatic suspend(input logic [7:0] feat);
        apb(1, FI, {24'h0, feat});
        inSuspend <= 1'b1;
        repeat (3) @(negedge clock);
        check({power_latch_bit0, cpuOutputsIdle}, 2'b01);
        @(posedge clock);
        inSuspend <= 1'b0;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        apb(0, MISC_CPU_CONTROL_IDX, 0);
        check(rd, {24'h0, RESET_VAL});
        apb(1, FI, 32'h0000001A);
        apb(0, FI, 0);
        check(rd, 32'h0000001A);
        apb(1, 8'h01, 32'h000000FF);
        check({31'h0, err}, 1);
        apb(1, MISC_CPU_CONTROL_IDX, 32'h00000080);
        check(linearBurst, 1);
        apb(1, MISC_CPU_CONTROL_IDX, 0);
        check(linearBurst, 0);
        local_device_claim_b <= 1'b0;
        apb(1, FI, 0);
        check(waitLocalClaim, 1);
        apb(1, FI, 32'(1 << FEAT_CLAIM_IGNORE));
        check(waitLocalClaim, 0);
        $display("test regs done");
    endtask
    task automatic t_pins();
        apb(1, FI, 0);
        check({pin130IsMask, pin130Out}, {1'b0, gateAddr20Val});
        check({pin80Func, pin80Out}, {2'd1, numericIrqVal});
        apb(1, FI, 32'(1 << FEAT_ADDR20_MASK_OUT_FORCE | 1 << FEAT_DMA_ACK_FORCE));
        check({pin130IsMask, pin130Out}, {1'b1, addr20MaskVal});
        check({pin80Func, pin80Out}, {2'd0, dmaAckCh2Val_b});
        apb(1, LOCAL_MASTER_CFG_IDX, 32'(1 << LMC_MASTER_ENABLE));
        check({pin80Func, pin80Out},
              {2'd2, localMasterGrantVal_b});
        apb(1, LOCAL_MASTER_CFG_IDX, 0);
        $display("test pins done");
    endtask
    task automatic t_copro();
        apb(1, FI, 0);
        cycleStart <= 1'b1;
        cycleIo <= 1'b1;
        cpu_addr31 <= 1'b1;
        internalReady <= 1'b1;
        @(negedge clock);
        check(forwardLocal, 1);
        check(cpu_ready_oe, 0);
        apb(1, FI, 32'(1 << FEAT_COPROC_OVRD));
        check({forwardLocal, cpu_ready_oe}, 2'b01);
        $display("test coprocessor done");
    endtask
    // sync: oe lags ready_in; direct: oe in the same cycle
    task automatic t_ready(input logic direct);
        apb(1, FI, {31'h0, direct});
        copDly <= direct ? 4'h1 : 4'h3;
        copReq <= 1'b1;
        waitfor(3, 12);
        check(cpu_ready_oe, direct);
        waitfor(2, 8);
        check({cpu_ready_oe, cpu_ready_o}, 2'b10);
        @(posedge clock);
        copReq <= 1'b0;
        repeat (8) @(negedge clock);
        $display("test ready done");
    endtask
    task automatic t_reset();
        apb(1, FI, 0);
        pulse(1'b1);
        repeat (4) @(negedge clock);
        check(cpu_hard_reset, 0);
        cycleStart <= 1'b0;
        waitfor(0, 6);
        check(cpu_hard_reset, 1);
        waitfor(1, 4);
        check(cpu_soft_reset, 1);
        settle();
        pulse(1'b0);
        waitfor(1, 6);
        check(cpu_soft_reset, 1);
        settle();
        check(sawHard, 0);
        apb(1, FI, 32'(1 << FEAT_HARD_RST_NOW));
        cycleStart <= 1'b1;
        pulse(1'b1);
        waitfor(0, 4);
        check(cpu_hard_reset, 1);
        settle();
        cycleStart <= 1'b0;
        $display("test reset done");
    endtask
    task automatic t_resume();
        suspend(8'h28);
        @(negedge clock);
        check({power_latch_bit0, cpu_soft_reset}, 2'b10);
        waitfor(1, PD + 10);
        check({cpu_soft_reset, 31'(n >= PD)}, 32'h80000001);
        settle();
        check(sawHard, 0);
        suspend(8'h20);
        waitfor(0, PD + 12);
        check(cpu_hard_reset, 1);
        settle();
        $display("test resume done");
    endtask
    // ----------------------------------------------------------------
    // sequence and verdict
    // ----------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, cycleStart} = '0;
        {cycleIo, cpu_addr31, internalReady, softResetReq} = '0;
        {hardResetReq, inSuspend, copReq, copDly} = '0;
        {strap386, local_device_claim_b} = 2'b11;
        num_errors = 0;
        checks_done = 0;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        repeat (12) @(posedge clock);
        t_regs();
        t_pins();
        strap386 <= 1'b0;
        apb(1, FI, 0);
        check({pin130IsMask, pin80Func}, 3'b100);
        strap386 <= 1'b1;
        t_copro();
        t_ready(1'b0);
        t_ready(1'b1);
        t_reset();
        t_resume();
        stop_test();
    end
    // watchdog sized well past the expected run
    initial begin
        #(20 * 20000);
        num_errors++;
        stop_test();
    end
endmodule
